// >>> rtl/hce_pkg.sv
// Package: constants and types for the host charge emulation block
package hce_pkg;

    // ========================================================================
    // Mode field encodings
    // ========================================================================
    localparam logic [1:0] HCE_MODE_PASS    = 2'h0;   // High-speed pass-through
    localparam logic [1:0] HCE_MODE_CDP     = 2'h1;   // Automatic CDP
    localparam logic [1:0] HCE_MODE_DCP_2A4 = 2'h2;   // Automatic DCP, 2.4A bias
    localparam logic [1:0] HCE_MODE_DCP_1A0 = 2'h3;   // Automatic DCP, 1.0A bias
    localparam logic [1:0] HCE_MODE_RESET   = HCE_MODE_PASS;  // Startup value

    // ========================================================================
    // Timing
    // ========================================================================
    localparam int HCE_CLK_HZ      = 50000000;        // System clock rate
    localparam int HCE_IDLE_MS     = 500;             // Bus inactivity exit time
    localparam int HCE_IDLE_CYCLES = HCE_CLK_HZ / 1000 * HCE_IDLE_MS;

    // ========================================================================
    // Automatic CDP states
    // ========================================================================
    typedef enum logic [2:0] {
        HCE_SIGNALING,      // Resting: pulldowns and sink on
        HCE_PRIMARY,        // Source on negative line
        HCE_SECONDARY,      // Source off, nothing on positive line
        HCE_WAIT_ENUM,      // Waiting for enumeration level
        HCE_SESSION         // Data switches closed
    } hce_state_t;

endpackage : hce_pkg

// >>> rtl/hce_sync_if.sv
// Interface: synchronised comparator levels passed to the CDP engine
`timescale 1ns/100ps
`default_nettype none
interface hce_sync_if;
    logic dp_src_seen;   // 0.6V seen on positive line
    logic dm_src_seen;   // 0.6V seen on negative line
    logic enum_seen;     // 1.6V seen on either line
    logic bus_active;    // Traffic activity on the bus
    modport src (output dp_src_seen, output dm_src_seen, output enum_seen, output bus_active);
    modport dst (input dp_src_seen, input dm_src_seen, input enum_seen, input bus_active);
endinterface : hce_sync_if
`default_nettype wire

// >>> rtl/hce_pin_sync.sv
// Module: two-stage synchronisers for the analogue comparator outputs
`timescale 1ns/100ps
`default_nettype none
module hce_pin_sync
    import hce_pkg::*;
(
    input  wire logic clk,           // System clock
    input  wire logic rst,           // Asynchronous reset, high
    input  wire logic dp_src_raw,    // Raw 0.6V comparator, positive line
    input  wire logic dm_src_raw,    // Raw 0.6V comparator, negative line
    input  wire logic dp_enum_raw,   // Raw 1.6V comparator, positive line
    input  wire logic dm_enum_raw,   // Raw 1.6V comparator, negative line
    input  wire logic activity_raw,  // Raw bus activity detector
    hce_sync_if.src   lv             // Synchronised levels
);
    // ========================================================================
    // Two flops per input; only the second stage is read
    // ========================================================================
    logic [4:0] stage1;  // First stage
    logic [4:0] stage2;  // Second stage

    // Synchroniser chain
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= 5'h00;
            stage2 <= 5'h00;
        end
        else
        begin
            stage1 <= {activity_raw, dm_enum_raw, dp_enum_raw, dm_src_raw, dp_src_raw};
            stage2 <= stage1;
        end
    end

    assign lv.dp_src_seen = stage2[0];
    assign lv.dm_src_seen = stage2[1];
    assign lv.enum_seen   = stage2[2] | stage2[3];
    assign lv.bus_active  = stage2[4];
endmodule : hce_pin_sync
`default_nettype wire

// >>> rtl/hce_charge_emulation.sv
// Module: host charge emulation switch control and automatic CDP engine
`timescale 1ns/100ps
`default_nettype none
module hce_charge_emulation
    import hce_pkg::*;
#(
    parameter int IDLE_CYCLES = HCE_IDLE_CYCLES   // Inactivity limit in clocks
)
(
    input  wire logic       CLK,                      // 50 MHz clock
    input  wire logic       SYS_RST,                  // Async reset, high
    input  wire logic       FAULT_RESET,              // Fault: force off and reset
    input  wire logic       HIGHVOLT_SIDE_ENABLE,     // Pin, synchronised here
    input  wire logic       MODE_WR,                  // Mode write strobe
    input  wire logic [1:0] MODE_WDATA,               // Mode write data
    input  wire logic       DP_SRC_CMP,               // 0.6V comparator, positive
    input  wire logic       DM_SRC_CMP,               // 0.6V comparator, negative
    input  wire logic       DP_ENUM_CMP,              // 1.6V comparator, positive
    input  wire logic       DM_ENUM_CMP,              // 1.6V comparator, negative
    input  wire logic       BUS_ACTIVITY,             // Bus traffic detector
    output logic [1:0]      CHARGE_EMULATION_SELECT,  // Current mode field
    output logic            DATA_PATH_SWITCH,         // Data switches closed
    output logic            DETECT_PATH_SWITCH,       // Detection switches closed
    output logic            DATA_PULLDOWNS,           // 19k pulldowns on both lines
    output logic            DATA_CURRENT_SINK,        // Sink on positive line
    output logic            DATA_VOLTAGE_SOURCE,      // 0.6V on negative line
    output logic            DCP_BIAS_2A4,             // DCP bias select
    output logic            CDP_SESSION               // In session state
);
    // ========================================================================
    // Declarations
    // ========================================================================
    hce_sync_if  lv ();                // Synchronised levels
    hce_state_t  state;                // CDP engine state
    hce_state_t  next_state;           // Next engine state
    logic [1:0]  mode;                 // Mode field
    logic        en_s1;                // Enable sync stage one
    logic        en_s2;                // Enable sync stage two
    logic [31:0] idle_cnt;             // Inactivity counter
    logic        idle_done;            // Inactivity limit reached
    logic        blk_rst;              // Engine reset: fault, off or any mode other than CDP
    logic        cdp_on;               // CDP mode selected and enabled

    // ========================================================================
    // Input synchronisers
    // ========================================================================
    hce_pin_sync u_sync (
        .clk          (CLK),
        .rst          (SYS_RST),
        .dp_src_raw   (DP_SRC_CMP),
        .dm_src_raw   (DM_SRC_CMP),
        .dp_enum_raw  (DP_ENUM_CMP),
        .dm_enum_raw  (DM_ENUM_CMP),
        .activity_raw (BUS_ACTIVITY),
        .lv           (lv.src)
    );

    // Enable pin synchroniser
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            en_s1 <= 1'b0;
            en_s2 <= 1'b0;
        end
        else
        begin
            en_s1 <= HIGHVOLT_SIDE_ENABLE;
            en_s2 <= en_s1;
        end
    end

    // ========================================================================
    // Mode field
    // ========================================================================
    // Reset value pass-through; writes accepted at any time
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            mode <= HCE_MODE_RESET;
        else if (MODE_WR)
            mode <= MODE_WDATA;
    end

    assign CHARGE_EMULATION_SELECT = mode;
    // Engine is independent of attach status; faults, a low enable and any mode other than CDP reset it
    assign blk_rst = FAULT_RESET | ~en_s2 | (mode != HCE_MODE_CDP);
    assign cdp_on  = en_s2 & (mode == HCE_MODE_CDP);

    // ========================================================================
    // Inactivity counter
    // ========================================================================
    // Counts silent cycles while in session; activity restarts it
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            idle_cnt <= 32'h0;
        else if (state != HCE_SESSION || lv.bus_active)
            idle_cnt <= 32'h0;
        else if (!idle_done)
            idle_cnt <= idle_cnt + 32'h1;
    end

    assign idle_done = (idle_cnt >= 32'(IDLE_CYCLES - 1));

    // ========================================================================
    // CDP engine
    // ========================================================================
    // Next-state logic
    always_comb
    begin
        next_state = state;
        case (state)
            HCE_SIGNALING:
                if (lv.dp_src_seen)
                    next_state = HCE_PRIMARY;
            HCE_PRIMARY:
                if (!lv.dp_src_seen)
                    next_state = HCE_SECONDARY;
            HCE_SECONDARY:
                if (lv.dm_src_seen)
                    next_state = HCE_WAIT_ENUM;
            HCE_WAIT_ENUM:
                if (lv.enum_seen)
                    next_state = HCE_SESSION;
            HCE_SESSION:
                if (idle_done)
                    next_state = HCE_SIGNALING;
            default:
                next_state = HCE_SIGNALING;
        endcase
    end

    // State register, self-advancing
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            state <= HCE_SIGNALING;
        else if (blk_rst)
            state <= HCE_SIGNALING;
        else
            state <= next_state;
    end

    // ========================================================================
    // Switch and analogue controls
    // ========================================================================
    // Registered outputs decoded from mode and state
    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            DATA_PATH_SWITCH    <= 1'b0;
            DETECT_PATH_SWITCH  <= 1'b0;
            DATA_PULLDOWNS      <= 1'b0;
            DATA_CURRENT_SINK   <= 1'b0;
            DATA_VOLTAGE_SOURCE <= 1'b0;
            DCP_BIAS_2A4        <= 1'b0;
            CDP_SESSION         <= 1'b0;
        end
        else if (!en_s2 || FAULT_RESET)
        begin
            // Everything open
            DATA_PATH_SWITCH    <= 1'b0;
            DETECT_PATH_SWITCH  <= 1'b0;
            DATA_PULLDOWNS      <= 1'b0;
            DATA_CURRENT_SINK   <= 1'b0;
            DATA_VOLTAGE_SOURCE <= 1'b0;
            DCP_BIAS_2A4        <= 1'b0;
            CDP_SESSION         <= 1'b0;
        end
        else
        begin
            DATA_PATH_SWITCH    <= (mode == HCE_MODE_PASS)
                                   || (cdp_on && state == HCE_SESSION);
            DETECT_PATH_SWITCH  <= (mode[1] == 1'b1)
                                   || (cdp_on && state != HCE_SESSION);
            DATA_PULLDOWNS      <= cdp_on && state != HCE_SESSION;
            DATA_CURRENT_SINK   <= cdp_on && state != HCE_SESSION;
            // Source only during primary; off again for secondary
            DATA_VOLTAGE_SOURCE <= cdp_on && state == HCE_PRIMARY;
            DCP_BIAS_2A4        <= (mode == HCE_MODE_DCP_2A4);
            CDP_SESSION         <= cdp_on && state == HCE_SESSION;
        end
    end

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    off_opens_all_a: assert property (!en_s2 |=> !DATA_PATH_SWITCH && !DETECT_PATH_SWITCH)
        else $error("switches closed while disabled");
    rest_bias_a: assert property (cdp_on && !FAULT_RESET && state == HCE_SIGNALING |=>
        DETECT_PATH_SWITCH && !DATA_PATH_SWITCH && DATA_PULLDOWNS && DATA_CURRENT_SINK)
        else $error("resting bias wrong");
    auto_advance_a: assert property (state == HCE_SIGNALING && lv.dp_src_seen && !blk_rst
        |=> state == HCE_PRIMARY)
        else $error("engine did not advance");
    src_on_a: assert property (state == HCE_PRIMARY && cdp_on && !FAULT_RESET
        |=> DATA_VOLTAGE_SOURCE)
        else $error("source not on");
    src_off_a: assert property (state == HCE_SECONDARY |=> !DATA_VOLTAGE_SOURCE)
        else $error("source on in secondary");
    enum_session_a: assert property (state == HCE_WAIT_ENUM && lv.enum_seen && !blk_rst
        |=> state == HCE_SESSION ##1 DATA_PATH_SWITCH)
        else $error("no session on enumeration");
    idle_exit_a: assert property (state == HCE_SESSION && idle_done && !blk_rst
        |=> state == HCE_SIGNALING)
        else $error("session not left");
    data_gate_a: assert property (cdp_on && state != HCE_SESSION && !FAULT_RESET
        |=> !DATA_PATH_SWITCH)
        else $error("data passed outside session");
    mode_write_a: assert property (MODE_WR |=> mode == $past(MODE_WDATA))
        else $error("mode write lost");
    fault_reset_a: assert property (FAULT_RESET |=> state == HCE_SIGNALING)
        else $error("fault did not reset engine");

    primary_c: cover property (state == HCE_PRIMARY);
    session_c: cover property (state == HCE_SESSION);
    idle_exit_c: cover property (state == HCE_SESSION ##1 state == HCE_SIGNALING);
    dcp_c: cover property (en_s2 && mode == HCE_MODE_DCP_1A0);
endmodule : hce_charge_emulation
`default_nettype wire

// >>> verif/hce_portable_model.sv
// Model: portable device running BC1.2 detection against the block
`timescale 1ns/100ps
`default_nettype none
module hce_portable_model
#(
    parameter int DELAY = 3    // Cycles spent instead of contact detection
)
(
    input  wire logic clk,       // System clock
    input  wire logic start,     // Rising edge begins an attach
    input  wire logic use_dm,    // Enumerate on the negative line
    input  wire logic host_src,  // Host 0.6V source on negative line
    input  wire logic data_sw,   // Host data switches closed
    output logic      dp_src,    // Our 0.6V on positive line
    output logic      dm_src,    // Our 0.6V on negative line
    output logic      dp_enum,   // Enumeration level, positive line
    output logic      dm_enum,   // Enumeration level, negative line
    output logic      activity,  // Bus traffic
    output logic      cdp_seen,  // Port recognised as CDP
    output logic      done       // Attach sequence finished
);
    logic ok_pri;  // Host answered primary detection
    logic ok_sec;  // Host dropped its source
    // Bounded wait for the host source to reach a level
    task automatic wait_src(input logic lvl, output logic ok);
        int k;
        k = 0;
        while (host_src !== lvl && k < 40)
        begin
            @(posedge clk);
            #1 k++;
        end
        ok = (host_src === lvl);
    endtask : wait_src
    // ========================================================================
    // Attach sequence; released lines fall to the host pulldowns
    // ========================================================================
    initial
    begin
        {dp_src, dm_src, dp_enum, dm_enum, activity, cdp_seen, done} = '0;
        forever
        begin
            @(posedge start);
            done = 1'b0;
            repeat (DELAY) @(posedge clk);
            #1 dp_src = 1'b1;
            wait_src(1'b1, ok_pri);
            repeat (DELAY) @(posedge clk);
            #1 dp_src = 1'b0;
            wait_src(1'b0, ok_sec);
            dm_src = 1'b1;
            repeat (DELAY + 4) @(posedge clk);
            #1 cdp_seen = ok_pri & ok_sec & (host_src === 1'b0);
            dm_src = 1'b0;
            dp_enum = !use_dm;
            dm_enum = use_dm;
            // Look at the host switch just after the edge, once it has settled
            for (int k = 0; k < 40 && data_sw !== 1'b1; k++)
            begin
                @(posedge clk);
                #1;
            end
            {dp_enum, dm_enum} = 2'h0;
            activity = 1'b1;
            repeat (20) @(posedge clk);
            #1 activity = 1'b0;
            // Late update so the bench sees done on its next look, never racing it
            done <= 1'b1;
        end
    end
endmodule : hce_portable_model
`default_nettype wire

// >>> verif/tb.sv
// Testbench: switch modes and automatic CDP flow of the charge emulation block
`timescale 1ns/100ps
`default_nettype none
module tb
    import hce_pkg::*;
;
    localparam int IDLE = 50;  // Shortened inactivity limit
    logic       CLK, SYS_RST, FAULT_RESET, HIGHVOLT_SIDE_ENABLE, MODE_WR;
    logic [1:0] MODE_WDATA, SEL;
    logic       DP_SRC, DM_SRC, DP_ENUM, DM_ENUM, ACT;
    logic       DATA_SW, DET_SW, PULLD, SINK, VSRC, BIAS, SESS;
    logic       start, dm_sel, cdp_seen, done;
    int         miscompares = 0;
    int         n_tests = 0;
    hce_charge_emulation #(.IDLE_CYCLES(IDLE)) DUT (.CLK(CLK), .SYS_RST(SYS_RST),
        .FAULT_RESET(FAULT_RESET), .HIGHVOLT_SIDE_ENABLE(HIGHVOLT_SIDE_ENABLE),
        .MODE_WR(MODE_WR), .MODE_WDATA(MODE_WDATA), .DP_SRC_CMP(DP_SRC),
        .DM_SRC_CMP(DM_SRC), .DP_ENUM_CMP(DP_ENUM), .DM_ENUM_CMP(DM_ENUM),
        .BUS_ACTIVITY(ACT), .CHARGE_EMULATION_SELECT(SEL), .DATA_PATH_SWITCH(DATA_SW),
        .DETECT_PATH_SWITCH(DET_SW), .DATA_PULLDOWNS(PULLD), .DATA_CURRENT_SINK(SINK),
        .DATA_VOLTAGE_SOURCE(VSRC), .DCP_BIAS_2A4(BIAS), .CDP_SESSION(SESS));
    hce_portable_model PEER (.clk(CLK), .start(start), .use_dm(dm_sel), .host_src(VSRC),
        .data_sw(DATA_SW), .dp_src(DP_SRC), .dm_src(DM_SRC), .dp_enum(DP_ENUM),
        .dm_enum(DM_ENUM), .activity(ACT), .cdp_seen(cdp_seen), .done(done));
    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc
    task automatic chk_bit(input logic got, input logic exp, input string what);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask : chk_bit
    task automatic chk_mode(input logic [1:0] got, input logic [1:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error at %0t: mode got %h expected %h", $time, got, exp);
        end
    endtask : chk_mode
    // Two back-to-back mode writes; the second one wins
    task automatic wr(input logic [1:0] a, input logic [1:0] b);
        @(posedge CLK);
        #1 MODE_WR = 1'b1;
        MODE_WDATA = a;
        cyc(1);
        MODE_WDATA = b;
        cyc(1);
        MODE_WR = 1'b0;
        cyc(2);
    endtask : wr
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_modes;
        for (int m = 0; m < 4; m++)
        begin
            wr(2'(3 - m), 2'(m));
            chk_mode(SEL, 2'(m));
            chk_bit(DATA_SW, m == 0, "data sw");
            chk_bit(DET_SW, m != 0, "detect sw");
            chk_bit(BIAS, m == 2, "bias");
        end
        wr(HCE_MODE_CDP, HCE_MODE_CDP);
        chk_bit(PULLD, 1'b1, "pulldowns");
        chk_bit(SINK, 1'b1, "sink");
        chk_bit(VSRC, 1'b0, "source");
        HIGHVOLT_SIDE_ENABLE = 1'b0;
        cyc(5);
        chk_bit(DET_SW, 1'b0, "detect off");
        chk_bit(DATA_SW, 1'b0, "data off");
        HIGHVOLT_SIDE_ENABLE = 1'b1;
        cyc(5);
    endtask : t_modes
    // Detection up to the start of a session
    task automatic run_detect(input logic on_dm);
        int k;
        dm_sel = on_dm;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        for (k = 0; k < 60 && VSRC !== 1'b1; k++)
            cyc(1);
        chk_bit(VSRC, 1'b1, "primary source");
        chk_bit(DATA_SW, 1'b0, "data in detect");
        for (k = 0; k < 300 && done !== 1'b1; k++)
            cyc(1);
        chk_bit(cdp_seen, 1'b1, "cdp seen");
        chk_bit(SESS, 1'b1, "session");
        chk_bit(DATA_SW, 1'b1, "data session");
        chk_bit(DET_SW, 1'b0, "detect session");
    endtask : run_detect
    task automatic t_cdp(input logic on_dm);
        run_detect(on_dm);
        cyc(IDLE - 1);
        chk_bit(SESS, 1'b1, "session held");
        cyc(4);
        chk_bit(SESS, 1'b0, "session end");
        chk_bit(DATA_SW, 1'b0, "data reopened");
        chk_bit(SINK, 1'b1, "resting sink");
    endtask : t_cdp
    task automatic t_fault;
        run_detect(1'b0);
        FAULT_RESET = 1'b1;
        cyc(4);
        chk_bit(DATA_SW, 1'b0, "fault data");
        chk_bit(SESS, 1'b0, "fault session");
        FAULT_RESET = 1'b0;
        cyc(5);
        chk_bit(DET_SW, 1'b1, "fault resting");
    endtask : t_fault
    // ========================================================================
    // Clock, watchdog and main sequence
    // ========================================================================
    initial
    begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    initial
    begin
        #(20 * 8000);
        miscompares++;
        final_report();
    end
    initial
    begin
        {SYS_RST, HIGHVOLT_SIDE_ENABLE} = 2'h3;
        {FAULT_RESET, MODE_WR, start, dm_sel} = 4'h0;
        MODE_WDATA = 2'h0;
        cyc(20);
        chk_mode(SEL, HCE_MODE_RESET);
        chk_bit(DATA_SW, 1'b0, "reset data");
        SYS_RST = 1'b0;
        cyc(5);
        chk_bit(DATA_SW, 1'b1, "startup pass");
        t_modes();
        wr(HCE_MODE_CDP, HCE_MODE_CDP);
        t_cdp(1'b0);
        t_cdp(1'b1);
        t_fault();
        // Master parks the field at pass-through ahead of a role swap
        wr(HCE_MODE_PASS, HCE_MODE_PASS);
        chk_bit(DATA_SW, 1'b1, "swap data");
        chk_bit(DET_SW, 1'b0, "swap detect");
        final_report();
    end
endmodule : tb
`default_nettype wire
